// file: mode_defs.svh
// register offsets, field positions, reset values and timing counts for mode control
`ifndef MODE_DEFS_SVH
`define MODE_DEFS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------------
`define OFS_CMD 8'h00
`define OFS_STATUS 8'h04
`define OFS_CHAN 8'h08
`define OFS_DIAG 8'h0C
`define OFS_IRQ_STAT 8'h10
`define OFS_IRQ_MASK 8'h14

// ----------------------------------------------------------------------------
// command register bits (write only, read as zero except under under-voltage, when the status frame is returned)
// ----------------------------------------------------------------------------
`define CMD_WAKE_BIT 0
`define CMD_STANDBY_BIT 1
`define CMD_RESET_BIT 2

// ----------------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------------
`define ST_MODE_LSB 0
`define ST_MODE_MSB 1
`define ST_FALLBACK_BIT 2
`define ST_ERR_FLAG_BIT 3
`define ST_UV_BIT 4
`define ST_BATT_OK_BIT 5
`define ST_LOGIC_OK_BIT 6

// ----------------------------------------------------------------------------
// interrupt event bits
// ----------------------------------------------------------------------------
`define IRQ_RESET_BIT 0
`define IRQ_FB_ENTER_BIT 1
`define IRQ_FB_EXIT_BIT 2
`define IRQ_WAKE_BIT 3
`define IRQ_DIAG_BIT 4
`define IRQ_W 5

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CHAN_RST 8'h00
`define DIAG_RST 8'h00
`define IRQ_MASK_RST 5'h00
`define IRQ_STAT_RST 5'h00

// ----------------------------------------------------------------------------
// channel numbers routed from the input pins during fallback
// ----------------------------------------------------------------------------
`define FB_CHAN_A 4
`define FB_CHAN_B 5

// ----------------------------------------------------------------------------
// supply thresholds seen by the external comparators, in millivolts
// ----------------------------------------------------------------------------
`define BATT_UV_MV 5500
`define LOGIC_UV_MV 3000

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define UV_DELAY_NS 1000
`define UV_DELAY_CYC (`UV_DELAY_NS / `CLK_PERIOD_NS)
`define FILT_CYC (`UV_DELAY_CYC / 4)

`endif

// file: mode_pkg.sv
// types shared by the mode and reset control block
package mode_pkg;

  // ----------------------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SLEEP = 2'b00,
    MODE_ACTIVE = 2'b01,
    MODE_FALLBACK = 2'b10
  } mode_t;

  typedef logic [7:0] chan_t;

endpackage : mode_pkg

// file: pin_filter.sv
// two-flop synchroniser plus stability filter for a group of pins
`timescale 1ns/10ps

module pin_filter #(
  parameter int WIDTH = 1,
  parameter int FILT = 25
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // raw pins and filtered levels
  input wire logic [WIDTH-1:0] pin_raw,
  input wire logic [WIDTH-1:0] rst_val,
  output logic [WIDTH-1:0] pin_filt
);

  localparam int CW = $clog2(FILT + 1);
  localparam logic [CW-1:0] FILT_C = CW'(FILT);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      logic [CW-1:0] cnt_reg;
      logic out_reg;

      // first flop feeds only the second one
      always_ff @(posedge clk) begin
        meta_reg <= pin_raw[g];
        sync_reg <= meta_reg;
      end

      // level must hold FILT cycles before it is passed on, short spikes are dropped
      always_ff @(posedge clk) begin
        if (rst) begin
          cnt_reg <= '0;
          out_reg <= rst_val[g];
        end else if (sync_reg == out_reg) begin
          cnt_reg <= '0;
        end else if (cnt_reg == FILT_C - CW'(1)) begin
          cnt_reg <= '0;
          out_reg <= sync_reg;
        end else begin
          cnt_reg <= cnt_reg + CW'(1);
        end
      end

      assign pin_filt[g] = out_reg;
    end
  endgenerate

endmodule : pin_filter

// file: mode_and_reset_control.sv
// operating mode, fallback and reset control with an APB register slave
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "mode_defs.svh"

module mode_and_reset_control #(
  parameter int ADDR_W = 8,
  parameter int NCHAN = 8
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // supply comparators, high while the supply is above its threshold
  input wire logic BATTERY_SUPPLY_OK,
  input wire logic LOGIC_SUPPLY_OK,
  // fallback input and direct input pins
  input wire logic FALLBACK_INPUT,
  input wire logic IN1,
  input wire logic IN2,
  // diagnosis events from the power stages, one cycle each
  input wire logic [NCHAN-1:0] DIAG_EVT,
  // channel drive and state
  output mode_pkg::chan_t CHAN_ON,
  output mode_pkg::mode_t MODE,
  output logic IRQ
);

  import mode_pkg::*;

  // ----------------------------------------------------------------------------
  // pin conditioning
  // ----------------------------------------------------------------------------
  localparam int NPIN = 5;
  logic [NPIN-1:0] pins_raw;
  logic [NPIN-1:0] pins_f;
  logic batt_ok;
  logic logic_ok;
  logic fb_in;
  logic in1_f;
  logic in2_f;

  assign pins_raw = {IN2, IN1, FALLBACK_INPUT, LOGIC_SUPPLY_OK, BATTERY_SUPPLY_OK};

  // sync 2 + filter + 1 flop stays well inside the 1 us budget
  pin_filter #(
    .WIDTH(NPIN),
    .FILT(`FILT_CYC)
  ) u_pins (
    .clk(SYS_CLK),
    .rst(RST),
    .pin_raw(pins_raw),
    .rst_val(5'h00),
    .pin_filt(pins_f)
  );

  assign batt_ok = pins_f[0];
  assign logic_ok = pins_f[1];
  assign fb_in = pins_f[2];
  assign in1_f = pins_f[3];
  assign in2_f = pins_f[4];

  // ----------------------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------------------
  logic uv_active;
  logic apb_acc;
  logic wr_acc;
  logic cmd_hit;
  logic cmd_ok;
  logic wake_cmd;
  logic stby_cmd;
  logic rst_cmd;
  logic bank_clear;
  logic mapped;
  mode_t state_reg;
  mode_t state_next;
  logic pready_reg;

  // released only once both comparators say good
  assign uv_active = !(batt_ok && logic_ok);

  // apb access completes on the edge where pready is seen high
  assign apb_acc = PSEL && PENABLE && pready_reg;
  assign wr_acc = apb_acc && PWRITE;

  // commands are refused during fallback and under-voltage
  assign cmd_ok = (state_reg != MODE_FALLBACK) && !fb_in && !uv_active;
  assign cmd_hit = wr_acc && (PADDR == `OFS_CMD) && cmd_ok;
  assign wake_cmd = cmd_hit && PWDATA[`CMD_WAKE_BIT];
  assign stby_cmd = cmd_hit && PWDATA[`CMD_STANDBY_BIT];
  assign rst_cmd = cmd_hit && PWDATA[`CMD_RESET_BIT];

  // any source clears the bank; sleep holds it cleared
  assign bank_clear = uv_active || rst_cmd || fb_in
    || (state_reg != MODE_ACTIVE) || (state_next == MODE_SLEEP);

  // ----------------------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------------------
  // fallback first, then its exit, then supply, then host commands
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      MODE_SLEEP: begin
        if (fb_in) begin
          state_next = MODE_FALLBACK;
        end else if (wake_cmd && !stby_cmd) begin
          state_next = MODE_ACTIVE;
        end
      end
      MODE_ACTIVE: begin
        if (fb_in) begin
          state_next = MODE_FALLBACK;
        end else if (uv_active || stby_cmd) begin
          state_next = MODE_SLEEP;
        end
      end
      MODE_FALLBACK: begin
        if (!fb_in) begin
          state_next = MODE_SLEEP;
        end
      end
      default: begin
        state_next = MODE_SLEEP;
      end
    endcase
  end

  // power-up and RST start in sleep
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state_reg <= MODE_SLEEP;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------------
  // register bank: channel enables and diagnosis flags
  // ----------------------------------------------------------------------------
  chan_t chan_reg;
  logic [NCHAN-1:0] diag_reg;
  logic transfer_error_flag_reg;

  // writes only land while the bank is not held cleared
  always_ff @(posedge SYS_CLK) begin
    if (RST || bank_clear) begin
      chan_reg <= `CHAN_RST;
    end else if (wr_acc && (PADDR == `OFS_CHAN)) begin
      chan_reg <= PWDATA[7:0];
    end
  end

  // diagnosis flags stay readable in fallback; reset command and supply loss clear them
  always_ff @(posedge SYS_CLK) begin
    if (RST || rst_cmd || uv_active || (state_reg == MODE_SLEEP)) begin
      diag_reg <= `DIAG_RST;
    end else begin
      for (int i = 0; i < NCHAN; i++) begin
        if (DIAG_EVT[i]) begin
          diag_reg[i] <= 1'b1;
        end else if (wr_acc && (PADDR == `OFS_DIAG) && PWDATA[i] && cmd_ok) begin
          diag_reg[i] <= 1'b0;
        end
      end
    end
  end

  // error flag: set by any reset source, write one to clear; set wins
  always_ff @(posedge SYS_CLK) begin
    if (RST || uv_active || rst_cmd || (fb_in && state_reg != MODE_FALLBACK)
        || (state_reg == MODE_ACTIVE && state_next == MODE_SLEEP)) begin
      transfer_error_flag_reg <= 1'b1;
    end else if (wr_acc && (PADDR == `OFS_STATUS) && PWDATA[`ST_ERR_FLAG_BIT] && cmd_ok) begin
      transfer_error_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // channel outputs
  // ----------------------------------------------------------------------------
  chan_t chan_drv_reg;

  // fallback routes the pins straight to the two auto-configuring channels
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      chan_drv_reg <= `CHAN_RST;
    end else if (fb_in || state_reg == MODE_FALLBACK) begin
      chan_drv_reg <= `CHAN_RST;
      chan_drv_reg[`FB_CHAN_A] <= in1_f && fb_in;
      chan_drv_reg[`FB_CHAN_B] <= in2_f && fb_in;
    end else if (bank_clear) begin
      chan_drv_reg <= `CHAN_RST;
    end else begin
      chan_drv_reg <= chan_reg;
    end
  end

  assign CHAN_ON = chan_drv_reg;

  // mode shown on a port straight from a flop
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      MODE <= MODE_SLEEP;
    end else begin
      MODE <= state_next;
    end
  end

  // ----------------------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------------------
  logic [`IRQ_W-1:0] irq_stat_reg;
  logic [`IRQ_W-1:0] irq_mask_reg;
  logic [`IRQ_W-1:0] irq_evt;
  logic irq_reg;

  assign irq_evt[`IRQ_RESET_BIT] = rst_cmd || (uv_active && !transfer_error_flag_reg);
  assign irq_evt[`IRQ_FB_ENTER_BIT] = (state_reg != MODE_FALLBACK) && (state_next == MODE_FALLBACK);
  assign irq_evt[`IRQ_FB_EXIT_BIT] = (state_reg == MODE_FALLBACK) && (state_next == MODE_SLEEP);
  assign irq_evt[`IRQ_WAKE_BIT] = (state_reg == MODE_SLEEP) && (state_next == MODE_ACTIVE);
  assign irq_evt[`IRQ_DIAG_BIT] = |DIAG_EVT;

  // sticky status, write one to clear, an event in the clearing cycle wins
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      irq_stat_reg <= `IRQ_STAT_RST;
    end else begin
      for (int i = 0; i < `IRQ_W; i++) begin
        if (irq_evt[i]) begin
          irq_stat_reg[i] <= 1'b1;
        end else if (wr_acc && (PADDR == `OFS_IRQ_STAT) && PWDATA[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  // mask kept outside the bank so fallback does not lose the host's setup
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      irq_mask_reg <= `IRQ_MASK_RST;
    end else if (wr_acc && (PADDR == `OFS_IRQ_MASK)) begin
      irq_mask_reg <= PWDATA[`IRQ_W-1:0];
    end
  end

  // level output, one cycle behind the status bits
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  assign IRQ = irq_reg;

  // ----------------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  // status frame; works on logic supply alone
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`ST_MODE_MSB:`ST_MODE_LSB] = state_reg;
    status_word[`ST_FALLBACK_BIT] = fb_in;
    status_word[`ST_ERR_FLAG_BIT] = transfer_error_flag_reg;
    status_word[`ST_UV_BIT] = uv_active;
    status_word[`ST_BATT_OK_BIT] = batt_ok;
    status_word[`ST_LOGIC_OK_BIT] = logic_ok;
  end

  // read mux; under-voltage answers every address with the status frame
  always_comb begin
    mapped = 1'b1;
    rd_word = 32'h0000_0000;
    if (uv_active) begin
      rd_word = status_word;
      rd_word[`ST_ERR_FLAG_BIT] = 1'b1;
    end else begin
      unique case (PADDR)
        `OFS_CMD: rd_word = 32'h0000_0000;
        `OFS_STATUS: rd_word = status_word;
        `OFS_CHAN: rd_word = {24'h000000, chan_reg};
        `OFS_DIAG: rd_word = {24'h000000, diag_reg};
        `OFS_IRQ_STAT: rd_word = {27'h0000000, irq_stat_reg};
        `OFS_IRQ_MASK: rd_word = {27'h0000000, irq_mask_reg};
        default: mapped = 1'b0;
      endcase
    end
  end

  // one wait state: pready rises the cycle after the access phase starts
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (PSEL && PENABLE && !pready_reg) begin
      pready_reg <= 1'b1;
      prdata_reg <= PWRITE ? 32'h0000_0000 : rd_word;
      pslverr_reg <= !mapped && !uv_active;
    end else begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
  end

  assign PREADY = pready_reg;
  assign PRDATA = prdata_reg;
  assign PSLVERR = pslverr_reg;

endmodule : mode_and_reset_control

// file: mrc_checker_assertions.sv
// concurrent checks on the ports of the mode and reset controller
`timescale 1ns/10ps
`include "mode_defs.svh"

module mrc_checker #(
  parameter int ADDR_W = 8,
  parameter int NCHAN = 8
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // pins and state
  input wire logic BATTERY_SUPPLY_OK,
  input wire logic LOGIC_SUPPLY_OK,
  input wire logic FALLBACK_INPUT,
  input wire mode_pkg::chan_t CHAN_ON,
  input wire mode_pkg::mode_t MODE,
  input wire logic IRQ
);
  import mode_pkg::*;
  // -------------------------------------------------------------------------
  // helper counters, saturating at 100 cycles (one microsecond)
  // -------------------------------------------------------------------------
  logic [6:0] good_cnt;
  logic [6:0] low_cnt;
  logic [6:0] fb_cnt;
  logic wake_wr;
  function automatic logic [6:0] sat(input logic [6:0] c, input logic en);
    return !en ? 7'h00 : ((c == 7'h64) ? c : c + 7'h01);
  endfunction : sat
  // wake written with standby clear, other bits not looked at, at the committing edge
  assign wake_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == `OFS_CMD && PWDATA[0]
    && !PWDATA[1];
  // pins are asynchronous, so only long steady levels are judged
  always_ff @(posedge SYS_CLK) begin
    good_cnt <= RST ? 7'h00 : sat(good_cnt, BATTERY_SUPPLY_OK && LOGIC_SUPPLY_OK);
    low_cnt <= RST ? 7'h00 : sat(low_cnt, !(BATTERY_SUPPLY_OK && LOGIC_SUPPLY_OK));
    fb_cnt <= RST ? 7'h00 : sat(fb_cnt, FALLBACK_INPUT);
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_reset_state: assert property ($fell(RST) |-> MODE == MODE_SLEEP
    && CHAN_ON == 8'h00) else $error("state not cleared by reset");
  a_wake_cause: assert property ((MODE == MODE_ACTIVE && $past(MODE) == MODE_SLEEP)
    |-> $past(wake_wr) || $past(wake_wr, 2)) else $error("active entered without wake");
  a_sleep_off: assert property ((MODE == MODE_SLEEP) [*3] |-> CHAN_ON == 8'h00)
    else $error("channel on in sleep");
  a_fb_exit: assert property (($past(MODE) == MODE_FALLBACK && MODE != MODE_FALLBACK)
    |-> MODE == MODE_SLEEP) else $error("fallback left to a state other than sleep");
  a_fb_chan: assert property ((MODE == MODE_FALLBACK) [*3] |-> (CHAN_ON & 8'hCF) == 8'h00)
    else $error("channel other than 4 or 5 on in fallback");
  a_fb_wake: assert property ((fb_cnt > 7'h28 && good_cnt > 7'h28)
    |-> MODE == MODE_FALLBACK) else $error("fallback input did not take over");
  a_uv_sleep: assert property (low_cnt == 7'h64 |-> MODE == MODE_SLEEP
    && CHAN_ON == 8'h00) else $error("under-voltage not in effect after one microsecond");
  a_uv_read: assert property ((low_cnt > 7'h28 && PREADY && !PWRITE)
    |-> PRDATA[3] && PRDATA[4] && !PSLVERR) else $error("read in under-voltage lacks error flag");
  a_ready_wait: assert property ((PSEL && PENABLE && !PREADY) |=> PREADY ##1 !PREADY)
    else $error("apb answer not a single wait state pulse");
  a_unmapped_err: assert property ((PREADY && PADDR == 8'h18 && good_cnt > 7'h28)
    |-> PSLVERR && PRDATA == 32'h0) else $error("unmapped access not refused");
  c_fallback: cover property (MODE == MODE_FALLBACK);
  c_uv: cover property (low_cnt == 7'h64);
  c_unmapped: cover property (PREADY && PSLVERR);
endmodule : mrc_checker

bind mode_and_reset_control mrc_checker #(.ADDR_W(ADDR_W), .NCHAN(NCHAN)) chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .BATTERY_SUPPLY_OK(BATTERY_SUPPLY_OK), .LOGIC_SUPPLY_OK(LOGIC_SUPPLY_OK),
  .FALLBACK_INPUT(FALLBACK_INPUT), .CHAN_ON(CHAN_ON), .MODE(MODE), .IRQ(IRQ));

// file: apb_host.sv
// host controller model: apb master issuing register transfers
`timescale 1ns/10ps

module apb_host (
  // clock
  input wire logic SYS_CLK,
  // request
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [7:0] PADDR,
  output logic [31:0] PWDATA,
  // answer
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  // idle bus at time zero
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
  end
  // one transfer; request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // released lines must not keep the last value
    PADDR <= ~a;
    PWDATA <= ~d;
  endtask : xfer
endmodule : apb_host

// file: testbench.sv
// self-checking bench for the mode and reset controller
`timescale 1ns/10ps

module testbench;
  import mode_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] v; logic e; chan_t c; logic i;} row_t;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic bat_ok, log_ok, fb, in1, in2, irq;
  logic [7:0] paddr, diag;
  logic [31:0] pwdata, prdata, rd;
  chan_t chan_on;
  mode_t mode;
  int errors, samples_checked, cyc;
  // write data for writes, expected read data for reads; irq x means not judged
  row_t rows[23] = '{
    '{1'b0,8'h04,32'h68,1'b0,8'h00,1'b0}, '{1'b1,8'h04,32'h08,1'b0,8'h00,1'b0},
    '{1'b0,8'h04,32'h60,1'b0,8'h00,1'b0}, '{1'b1,8'h00,32'h01,1'b0,8'h00,1'b0},
    '{1'b0,8'h04,32'h61,1'b0,8'h00,1'b0}, '{1'b1,8'h08,32'hA5,1'b0,8'hA5,1'b0},
    '{1'b0,8'h08,32'hA5,1'b0,8'hA5,1'b0}, '{1'b1,8'h14,32'h08,1'b0,8'hA5,1'b1},
    '{1'b1,8'h14,32'h00,1'b0,8'hA5,1'b0}, '{1'b1,8'h14,32'h1F,1'b0,8'hA5,1'b1},
    '{1'b1,8'h10,32'h1F,1'b0,8'hA5,1'b0}, '{1'b0,8'h10,32'h00,1'b0,8'hA5,1'b0},
    '{1'b0,8'h18,32'h00,1'b1,8'hA5,1'b0}, '{1'b1,8'h00,32'h04,1'b0,8'h00,1'b1},
    '{1'b0,8'h04,32'h69,1'b0,8'h00,1'b1}, '{1'b0,8'h08,32'h00,1'b0,8'h00,1'b1},
    '{1'b1,8'h14,32'h00,1'b0,8'h00,1'b0}, '{1'b1,8'h04,32'h08,1'b0,8'h00,1'b0},
    '{1'b1,8'h08,32'h0F,1'b0,8'h0F,1'b0}, '{1'b1,8'h00,32'h03,1'b0,8'h00,1'b0},
    '{1'b0,8'h04,32'h68,1'b0,8'h00,1'b0}, '{1'b1,8'h08,32'hFF,1'b0,8'h00,1'b0},
    '{1'b0,8'h08,32'h00,1'b0,8'h00,1'b0}};

  mode_and_reset_control dut (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .BATTERY_SUPPLY_OK(bat_ok), .LOGIC_SUPPLY_OK(log_ok),
    .FALLBACK_INPUT(fb), .IN1(in1), .IN2(in2), .DIAG_EVT(diag), .CHAN_ON(chan_on),
    .MODE(mode), .IRQ(irq));
  apb_host host (.SYS_CLK(clk), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

  // ---------------------------------------------------------------------------
  // clock, timeout and shared tasks
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // whole run needs under two thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      stop_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd, er);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, rd, er);
    chk(rd, exp);
  endtask : rd_chk
  task automatic stop_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    {errors, samples_checked, cyc} = '0;
    {rst, bat_ok, log_ok, fb, in1, in2, diag} = {3'b111, 3'b000, 8'h00};
    tick(2);
    rst <= 1'b0;
    tick(40); // filtered supplies settle before the first command
    for (int n = 0; n < 23; n++) begin
      host.xfer(rows[n].w, rows[n].a, rows[n].v, rd, er);
      tick(2);
      if (!rows[n].w) chk(rd, rows[n].v);
      chk(er, rows[n].e);
      chk(chan_on, rows[n].c);
      if (rows[n].i !== 1'bx) chk(irq, rows[n].i);
    end
    // fallback from active: first pin drives channel 4, commands and clears refused
    wr(8'h00, 32'h1);
    diag <= 8'h81;
    tick(1);
    diag <= 8'h00;
    in1 <= 1'b1;
    fb <= 1'b1;
    tick(40);
    chk(mode, MODE_FALLBACK);
    chk(chan_on, 8'h10);
    wr(8'h00, 32'h2);
    wr(8'h08, 32'hFF);
    wr(8'h0C, 32'h81);
    rd_chk(8'h04, 32'h6E);
    rd_chk(8'h0C, 32'h81);
    rd_chk(8'h08, 32'h0);
    chk(mode, MODE_FALLBACK);
    {fb, in1} <= 2'b00;
    tick(40);
    chk(mode, MODE_SLEEP);
    chk(chan_on, 8'h00);
    rd_chk(8'h0C, 32'h0);
    rd_chk(8'h10, 32'h1F);
    // the pin alone wakes a sleeping device; second pin drives channel 5
    {fb, in2} <= 2'b11;
    tick(40);
    chk(mode, MODE_FALLBACK);
    chk(chan_on, 8'h20);
    {fb, in2} <= 2'b00;
    tick(40);
    // under-voltage: one microsecond to act, released only with both supplies good
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h3);
    bat_ok <= 1'b0;
    tick(100);
    chk(mode, MODE_SLEEP);
    chk(chan_on, 8'h00);
    rd_chk(8'h08, 32'h58);
    wr(8'h00, 32'h1);
    {bat_ok, log_ok} <= 2'b10;
    tick(40);
    rd_chk(8'h0C, 32'h38);
    log_ok <= 1'b1;
    tick(40);
    rd_chk(8'h04, 32'h68);
    // second reset in mid-run with a channel on
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h5);
    tick(2);
    chk(chan_on, 8'h05);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    chk(mode, MODE_SLEEP);
    chk(chan_on, 8'h00);
    tick(40);
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h04, 32'h68);
    stop_test();
  end
endmodule : testbench
